// File: hdl/aux_digital_io_mux.sv
// auxiliary digital i/o: three filtered edge-detecting inputs and four
// source-selected outputs, two of them open drain, with an avalon-mm slave.
// assumes pins and status flags are synchronous-safe levels; inputs are
// still passed through a two-stage synchroniser.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each output driven by its source selector
// - fault source: 1 when fault occurred
// - phase source: 1 for single-phase configuration
// - relay source: 1 while output relay enabled
// - program source: 1 with steady-state program selected
// - remote source: 1 under remote control
// - transient source: 1 running, paused or stepping
// - coupling source: 1 when transformer coupled
// - per-output polarity invert complements source level
// - present output levels readable as status
// - rising input edges fire per-channel action event
// - falling input edges fire separate action event
// - filter length zero to ten million ms
// - open-drain outputs: 1 pulls pin low
module aux_digital_io_mux #(
   parameter int unsigned CYC_PER_MS = aux_dio_pkg::CYC_PER_MS
)(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // avalon-mm slave
   input  wire logic [7:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest,
   output logic             o_irq,
   // unit status conditions
   input  wire logic        i_fault_flag,
   input  wire logic        i_single_phase_config_flag,
   input  wire logic        i_relay_enabled_flag,
   input  wire logic        i_program_flag,
   input  wire logic        i_remote_flag,
   input  wire logic        i_transient_active_flag,
   input  wire logic        i_transformer_coupled_flag,
   // digital input pins
   input  wire logic [2:0]  i_din,
   output logic [2:0]       o_rise_event,
   output logic [2:0]       o_fall_event,
   // digital outputs: two push-pull, two open drain
   output logic [1:0]       o_ttl_out,
   output logic             o_open_drain_out_a_o,
   output logic             o_open_drain_out_a_oe,
   output logic             o_open_drain_out_b_o,
   output logic             o_open_drain_out_b_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0]            out_sel_reg;
   logic [3:0]             out_inv_reg;
   logic [3:0]             out_level_reg;
   logic [23:0]            filt_len_reg [3];
   logic [2:0]             sync1_reg;
   logic [2:0]             sync2_reg;
   logic [2:0]             filt_level_reg;
   logic [23:0]            stable_cnt_reg [3];
   logic [16:0]            tick_cnt_reg;
   logic                   ms_tick;
   logic [6:0]             irq_stat_reg;
   logic [6:0]             irq_en_reg;
   logic [6:0]             ev_set;
   logic                   wr_ack_reg;
   logic                   rd_ack_reg;
   logic [3:0]             src_level;

   // one wait state on every access keeps read data registered
   assign o_waitrequest = (i_read & ~rd_ack_reg) | (i_write & ~wr_ack_reg);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wr_ack_reg <= 1'b0;
         rd_ack_reg <= 1'b0;
      end
      else
      begin
         wr_ack_reg <= i_write & ~wr_ack_reg;
         rd_ack_reg <= i_read & ~rd_ack_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration writes
   // reset defaults
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         out_sel_reg <= aux_dio_pkg::OUT_SEL_RST;
         out_inv_reg <= aux_dio_pkg::OUT_INV_RST;
         irq_en_reg  <= 7'h00;
         for (int k = 0; k < 3; k++)
            filt_len_reg[k] <= aux_dio_pkg::FILT_RST;
      end
      // writes land on the second cycle, the edge where waitrequest is low
      else if (i_write && wr_ack_reg)
      begin
         if (i_address == aux_dio_pkg::OUT_SEL_OFS)
         begin
            if (i_byteenable[0])
               out_sel_reg[7:0] <= i_writedata[7:0];
            if (i_byteenable[1])
               out_sel_reg[15:8] <= i_writedata[15:8];
         end
         else if (i_address == aux_dio_pkg::OUT_INV_OFS)
         begin
            if (i_byteenable[0])
               out_inv_reg <= i_writedata[3:0];
         end
         else if (i_address == aux_dio_pkg::IRQ_EN_OFS)
         begin
            if (i_byteenable[0])
               irq_en_reg <= i_writedata[6:0];
         end
         else
         begin
            for (int k = 0; k < 3; k++)
            begin
               if (i_address == aux_dio_pkg::FILT0_OFS + 8'(4 * k))
               begin
                  // length saturates at the top of range
                  if (i_writedata[23:0] > 24'(aux_dio_pkg::FILTER_MS_MAX))
                     filt_len_reg[k] <= 24'(aux_dio_pkg::FILTER_MS_MAX);
                  else
                     filt_len_reg[k] <= i_writedata[23:0];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick for the input filters
   assign ms_tick = (tick_cnt_reg == 17'(CYC_PER_MS - 1));

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         tick_cnt_reg <= 17'h00000;
      else if (ms_tick)
         tick_cnt_reg <= 17'h00000;
      else
         tick_cnt_reg <= tick_cnt_reg + 17'h00001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // input synchroniser; first stage feeds only the second
   // two-stage sync
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end
      else
      begin
         sync1_reg <= i_din;
         sync2_reg <= sync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-input glitch filter and edge events
   // ms granularity: stability is counted in whole ticks, so a pulse may pass
   // up to one ms short of the setting
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_in
         // level changes after stable filter length
         always_ff @(posedge i_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               filt_level_reg[g]  <= 1'b0;
               stable_cnt_reg[g]  <= 24'h000000;
            end
            else if (sync2_reg[g] == filt_level_reg[g])
               stable_cnt_reg[g] <= 24'h000000;
            else if (stable_cnt_reg[g] >= filt_len_reg[g])
            begin
               filt_level_reg[g] <= sync2_reg[g];
               stable_cnt_reg[g] <= 24'h000000;
            end
            else if (ms_tick)
               stable_cnt_reg[g] <= stable_cnt_reg[g] + 24'h000001;
         end

         assign ev_set[aux_dio_pkg::RISE_POS + g] = (sync2_reg[g] != filt_level_reg[g])
            && (stable_cnt_reg[g] >= filt_len_reg[g]) && sync2_reg[g];
         assign ev_set[aux_dio_pkg::FALL_POS + g] = (sync2_reg[g] != filt_level_reg[g])
            && (stable_cnt_reg[g] >= filt_len_reg[g]) && !sync2_reg[g];
      end
   endgenerate
   assign ev_set[3] = 1'b0; // unused gap in the layout

   // event pulses as registered outputs
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_rise_event <= 3'h0;
         o_fall_event <= 3'h0;
      end
      else
      begin
         o_rise_event <= ev_set[2:0];
         o_fall_event <= ev_set[6:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky event status; a set in the clear cycle wins
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         irq_stat_reg <= 7'h00;
      else if (i_write && wr_ack_reg && i_address == aux_dio_pkg::IRQ_CLR_OFS && i_byteenable[0])
         irq_stat_reg <= (irq_stat_reg & ~i_writedata[6:0]) | ev_set;
      else
         irq_stat_reg <= irq_stat_reg | ev_set;
   end

   assign o_irq = |(irq_stat_reg & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////////
   // output source selection
   generate
      for (g = 0; g < 4; g++)
      begin : g_out
         always_comb
         begin
            case (out_sel_reg[4*g +: 4])
               aux_dio_pkg::SRC_HIGH:      src_level[g] = 1'b1;
               aux_dio_pkg::SRC_FAULT:     src_level[g] = i_fault_flag;
               aux_dio_pkg::SRC_PHASE:     src_level[g] = i_single_phase_config_flag;
               aux_dio_pkg::SRC_RELAY:     src_level[g] = i_relay_enabled_flag;
               aux_dio_pkg::SRC_PROGRAM:   src_level[g] = i_program_flag;
               aux_dio_pkg::SRC_REMOTE:    src_level[g] = i_remote_flag;
               aux_dio_pkg::SRC_TRANSIENT: src_level[g] = i_transient_active_flag;
               aux_dio_pkg::SRC_COUPLING:  src_level[g] = i_transformer_coupled_flag;
               default:                    src_level[g] = 1'b0; // low and unused codes
            endcase
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         out_level_reg <= 4'h0;
      else
         out_level_reg <= src_level ^ out_inv_reg;
   end

   assign o_ttl_out = out_level_reg[1:0];
   // logic 1 turns the fet on, pulling low
   assign o_open_drain_out_a_o  = 1'b0;
   assign o_open_drain_out_a_oe = out_level_reg[2];
   assign o_open_drain_out_b_o  = 1'b0;
   assign o_open_drain_out_b_oe = out_level_reg[3];

   ////////////////////////////////////////////////////////////////////////////
   // read data, registered on the wait-state cycle
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_readdata <= aux_dio_pkg::UNMAPPED_RDATA;
      else if (i_read && !rd_ack_reg)
      begin
         if (i_address == aux_dio_pkg::OUT_SEL_OFS)
            o_readdata <= {16'h0000, out_sel_reg};
         else if (i_address == aux_dio_pkg::OUT_INV_OFS)
            o_readdata <= {28'h0000000, out_inv_reg};
         else if (i_address == aux_dio_pkg::OUT_STATE_OFS)
            o_readdata <= {28'h0000000, out_level_reg};
         else if (i_address == aux_dio_pkg::IN_STATE_OFS)
            o_readdata <= {29'h00000000, filt_level_reg};
         else if (i_address == aux_dio_pkg::FILT0_OFS)
            o_readdata <= {8'h00, filt_len_reg[0]};
         else if (i_address == aux_dio_pkg::FILT0_OFS + 8'h04)
            o_readdata <= {8'h00, filt_len_reg[1]};
         else if (i_address == aux_dio_pkg::FILT0_OFS + 8'h08)
            o_readdata <= {8'h00, filt_len_reg[2]};
         else if (i_address == aux_dio_pkg::IRQ_STAT_OFS)
            o_readdata <= {25'h0000000, irq_stat_reg};
         else if (i_address == aux_dio_pkg::IRQ_EN_OFS)
            o_readdata <= {25'h0000000, irq_en_reg};
         else
            o_readdata <= aux_dio_pkg::UNMAPPED_RDATA;
      end
   end

endmodule
`default_nettype wire

// File: hdl/aux_dio_pkg.sv
// package for the auxiliary digital i/o block: register map, field layouts,
// reset values, source selector codes and timing constants.
// assumes a 100 MHz system clock and a 32-bit avalon-mm register bus.
package aux_dio_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clocking and filter timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned FILTER_MS_MAX   = 10_000_000;
   // cycles per millisecond tick, derived from the clock rate
   localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;
   localparam int unsigned TICK_W          = 17;
   localparam int unsigned FILT_W          = 24;

   ////////////////////////////////////////////////////////////////////////////
   // channel counts and widths
   localparam int unsigned N_IN            = 3;
   localparam int unsigned N_OUT           = 4;
   localparam int unsigned SEL_W           = 4;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [7:0] OUT_SEL_OFS      = 8'h00; // 4 bits per output
   localparam logic [7:0] OUT_INV_OFS      = 8'h04;
   localparam logic [7:0] OUT_STATE_OFS    = 8'h08;
   localparam logic [7:0] IN_STATE_OFS     = 8'h0C;
   localparam logic [7:0] FILT0_OFS        = 8'h10; // +4 per input channel
   localparam logic [7:0] IRQ_STAT_OFS     = 8'h20;
   localparam logic [7:0] IRQ_EN_OFS       = 8'h24;
   localparam logic [7:0] IRQ_CLR_OFS      = 8'h28;

   // status layout: bits [2:0] rising, bits [6:4] falling
   localparam int unsigned RISE_POS        = 0;
   localparam int unsigned FALL_POS        = 4;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] OUT_SEL_RST     = 16'h0000;
   localparam logic [3:0]  OUT_INV_RST     = 4'h0;
   localparam logic [23:0] FILT_RST        = 24'h000000;
   localparam logic [31:0] UNMAPPED_RDATA  = 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // output source selector codes
   localparam logic [3:0] SRC_LOW          = 4'h0;
   localparam logic [3:0] SRC_HIGH         = 4'h1;
   localparam logic [3:0] SRC_FAULT        = 4'h2;
   localparam logic [3:0] SRC_PHASE        = 4'h3;
   localparam logic [3:0] SRC_RELAY        = 4'h4;
   localparam logic [3:0] SRC_PROGRAM      = 4'h5;
   localparam logic [3:0] SRC_REMOTE       = 4'h6;
   localparam logic [3:0] SRC_TRANSIENT    = 4'h7;
   localparam logic [3:0] SRC_COUPLING     = 4'h8;

endpackage

// File: verification/aux_digital_io_mux_assertions.sv
// checker for the aux digital i/o block, bound onto its top module.
// sees top ports only; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module aux_digital_io_mux_assertions #(
   parameter int unsigned CYC_PER_MS = 10
)(
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic [7:0]  i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [31:0] o_readdata,
   input wire logic        o_waitrequest,
   input wire logic [2:0]  o_rise_event,
   input wire logic [2:0]  o_fall_event,
   input wire logic [1:0]  o_ttl_out,
   input wire logic        o_open_drain_out_a_o,
   input wire logic        o_open_drain_out_a_oe,
   input wire logic        o_open_drain_out_b_o,
   input wire logic        o_open_drain_out_b_oe
);
   logic       wr_seen_reg;
   logic [3:0] lvl;
   logic       rd_done;
   // present output levels in register order
   assign lvl = {o_open_drain_out_b_oe, o_open_drain_out_a_oe, o_ttl_out};
   assign rd_done = i_read && !o_waitrequest;
   // sticky: outputs may only move once software has written something
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         wr_seen_reg <= 1'b0;
      else if (i_write && !o_waitrequest)
         wr_seen_reg <= 1'b1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   ////////////////////////////////////////////////////////////////////////////
   property p_wait_first; $rose(i_read || i_write) |-> o_waitrequest; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
   property p_wait_second; (i_read || i_write) && o_waitrequest |=> !o_waitrequest; endproperty
   a_wait_second: assert property (p_wait_second) else $error("wait not done in second cycle");
   property p_zero_read; rd_done && i_address inside {8'h28, 8'h30} |-> o_readdata == 32'h0; endproperty
   a_zero_read: assert property (p_zero_read) else $error("empty place read nonzero");
   property p_readback; rd_done && i_address == 8'h08 |-> o_readdata[3:0] == $past(lvl); endproperty
   a_readback: assert property (p_readback) else $error("level readback wrong");
   property p_od_data; !o_open_drain_out_a_o && !o_open_drain_out_b_o; endproperty
   a_od_data: assert property (p_od_data) else $error("open drain data not low");
   property p_quiet; !wr_seen_reg |-> lvl == 4'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("output moved before setup");
   property p_pulse; (o_rise_event & $past(o_rise_event)) == 3'h0; endproperty
   a_pulse: assert property (p_pulse) else $error("rise event longer than a cycle");
   property p_excl; (o_rise_event & o_fall_event) == 3'h0; endproperty
   a_excl: assert property (p_excl) else $error("rise and fall together");
   c_rise: cover property (o_rise_event[0]);
   c_fall: cover property (o_fall_event[0]);
   c_od: cover property (o_open_drain_out_b_oe);
endmodule
`default_nettype wire

// File: verification/field_equipment.sv
// field wiring model: contacts on the inputs, pull-ups on open-drain pins.
// assumes the bench asks for input levels; released pins read high.
`timescale 1ns/1ps
`default_nettype none
module field_equipment (
   input  wire logic       i_clk,
   input  wire logic [2:0] i_level,
   input  wire logic       i_oe_a,
   input  wire logic       i_oe_b,
   output logic [2:0]      o_din,
   output logic            o_pin_a,
   output logic            o_pin_b
);
   // contacts settle just after an edge, never mid-cycle
   initial o_din = 3'h0;
   always @(posedge i_clk)
      o_din <= i_level;
   // fet pulls low
   // pull-up wins whenever the fet is off
   assign o_pin_a = i_oe_a ? 1'b0 : 1'b1;
   assign o_pin_b = i_oe_b ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: verification/aux_digital_io_mux_tb.sv
// self-checking bench for the aux digital i/o block over avalon-mm.
// assumes 100 MHz clock, field model on the pins, short ms tick.
`timescale 1ns/1ps
`default_nettype none
module aux_digital_io_mux_tb;
   localparam int unsigned CPM = 10;
   logic        i_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        rd_s = 1'b0;
   logic        wr_s = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [6:0]  flags = 7'h00;
   logic [2:0]  level = 3'h0;
   logic [31:0] rdata;
   logic        wait_s, irq, oe_a, oe_b, pin_a, pin_b;
   logic [2:0]  din, rise, fall;
   logic [1:0]  ttl;
   logic [6:0]  mask;
   logic [3:0]  lv;
   int          fail_count = 0;
   int          comparisons = 0;
   always #5 i_clk = ~i_clk;
   aux_digital_io_mux #(.CYC_PER_MS(CPM)) DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(addr),
      .i_read(rd_s), .i_write(wr_s), .i_writedata(wdata), .i_byteenable(4'hF), .o_readdata(rdata),
      .o_waitrequest(wait_s), .o_irq(irq), .i_fault_flag(flags[0]), .i_single_phase_config_flag(flags[1]),
      .i_relay_enabled_flag(flags[2]), .i_program_flag(flags[3]), .i_remote_flag(flags[4]),
      .i_transient_active_flag(flags[5]), .i_transformer_coupled_flag(flags[6]), .i_din(din),
      .o_rise_event(rise), .o_fall_event(fall), .o_ttl_out(ttl), .o_open_drain_out_a_o(),
      .o_open_drain_out_a_oe(oe_a), .o_open_drain_out_b_o(), .o_open_drain_out_b_oe(oe_b));
   field_equipment u_field (.i_clk(i_clk), .i_level(level), .i_oe_a(oe_a), .i_oe_b(oe_b),
      .o_din(din), .o_pin_a(pin_a), .o_pin_b(pin_b));
   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (fail_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon access; held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr_s <= w;
      rd_s <= !w;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (wait_s !== 1'b0 && n < 20);
      if (wait_s !== 1'b0)
      begin
         fail_count++;
         $display("BAD %0t bus hang", $time);
         results();
      end
      else
      begin
         q = rdata;
         wr_s <= 1'b0;
         rd_s <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   // pulses are one cycle, so sample mid-cycle
   task automatic wait_ev(input logic f, input int ch);
      int n;
      for (n = 0; n < 400; n++)
      begin
         @(negedge i_clk);
         if ((f ? fall[ch] : rise[ch]) === 1'b1)
            break;
      end
      chk(32'(n < 400), 32'h1);
      @(posedge i_clk); // back on the drive edge before new stimulus
   endtask
   task automatic pins(input logic [3:0] v);
      chk(32'({pin_b, pin_a, ttl}), 32'({~v[3:2], v[1:0]}));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      flags <= 7'h7F;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h08, 32'h0);
      for (int c = 0; c < 9; c++)
      begin
         wr(8'h00, {16'h0, {4{4'(c)}}});
         for (int f = 0; f < 2; f++)
         begin
            mask = (c > 1) ? 7'(1 << (c - 2)) : 7'h00;
            flags <= f ? mask : ~mask;
            lv = (c == 1 || (c > 1 && f == 1)) ? 4'hF : 4'h0;
            repeat (2) @(posedge i_clk);
            rd(8'h08, {28'h0, lv});
            pins(lv);
         end
      end
      wr(8'h00, 32'h1111);
      wr(8'h04, 32'h5);
      wr(8'h08, 32'hF);
      rd(8'h08, 32'hA);
      pins(4'hA);
      rd(8'h30, 32'h0);
      rd(8'h28, 32'h0);
      wr(8'h24, 32'h77);
      wr(8'h14, 32'h2);
      wr(8'h18, 32'hFFFFFF);
      rd(8'h18, 32'h989680);
      level <= 3'h1;
      wait_ev(1'b0, 0);
      rd(8'h0C, 32'h1);
      rd(8'h20, 32'h1);
      chk(32'(irq), 32'h1);
      wr(8'h28, 32'h1);
      @(negedge i_clk);
      chk(32'(irq), 32'h0);
      // short pulse on the filtered input while the other falls
      @(posedge i_clk);
      level <= 3'h2;
      wait_ev(1'b1, 0);
      level <= 3'h0;
      repeat (60) @(posedge i_clk);
      rd(8'h20, 32'h10);
      wr(8'h24, 32'h0);
      @(negedge i_clk);
      chk(32'(irq), 32'h0);
      @(posedge i_clk);
      level <= 3'h2;
      wait_ev(1'b0, 1);
      rd(8'h20, 32'h12);
      wr(8'h24, 32'h77);
      @(negedge i_clk);
      chk(32'(irq), 32'h1);
      wr(8'h28, 32'h77);
      rd(8'h20, 32'h0);
      chk(32'(irq), 32'h0);
      results();
   end
endmodule
bind aux_digital_io_mux aux_digital_io_mux_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.i_clk(i_clk),
   .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
   .o_waitrequest(o_waitrequest), .o_rise_event(o_rise_event), .o_fall_event(o_fall_event),
   .o_ttl_out(o_ttl_out), .o_open_drain_out_a_o(o_open_drain_out_a_o),
   .o_open_drain_out_a_oe(o_open_drain_out_a_oe), .o_open_drain_out_b_o(o_open_drain_out_b_o),
   .o_open_drain_out_b_oe(o_open_drain_out_b_oe));
`default_nettype wire
